// ### logic/skl_pkg.sv
// Package: register map, field layout and encodings of the key and lifecycle control block
package skl_pkg;
  // Register byte offsets
  localparam logic [15:0] ADDR_SUBSYSTEM_ENABLE = 16'h0500;
  localparam logic [15:0] ADDR_KEY_SOURCE_SELECT = 16'h1a38;
  localparam logic [15:0] ADDR_FIXED_KEY_LOCK = 16'h1a4c;
  localparam logic [15:0] ADDR_ROOT_KEY_WORD0 = 16'h1a50;
  localparam logic [15:0] ADDR_ROOT_KEY_WORD1 = 16'h1a54;
  localparam logic [15:0] ADDR_ROOT_KEY_WORD2 = 16'h1a58;
  localparam logic [15:0] ADDR_ROOT_KEY_WORD3 = 16'h1a5c;
  localparam logic [15:0] ADDR_LIFECYCLE_CONTROL = 16'h1a60;
  localparam logic [15:0] ADDR_DMA_LENGTH = 16'h1a70;
  localparam int ADDR_W = 16;
  // Field layout
  localparam int LCS_W = 4;
  localparam int LCS_VALID_BIT = 8;
  localparam int SEL_W = 2;
  localparam int KEY_W = 128;
  localparam int DMA_LEN_W = 16;
  // Encodings and reset values
  localparam logic [LCS_W-1:0] LCS_DEBUG = 4'h0;
  localparam logic [LCS_W-1:0] LCS_SECURE = 4'h2;
  localparam logic [LCS_W-1:0] LCS_RESET = 4'h2;
  localparam logic [SEL_W-1:0] SEL_ROOT = 2'h0;
  localparam logic [SEL_W-1:0] SEL_FIXED = 2'h1;
  localparam logic [SEL_W-1:0] SEL_SESSION = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ROOT_RETAINED_VAL = 32'h0000_0001;
  localparam logic [31:0] ROOT_EMPTY_VAL = 32'h0000_0000;
endpackage

// ### logic/skl_key_mux.sv
// Key source multiplexer in front of the AES key input
`timescale 1ns/1ps
module skl_key_mux
  import skl_pkg::*;
#(
  // Arbitrary fixed design key value, constant in hardware
  parameter logic [KEY_W-1:0] FIXED_KEY = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Selection
  input wire logic [SEL_W-1:0] key_sel,
  input wire logic fixed_locked,
  // Key sources
  input wire logic [KEY_W-1:0] root_key,
  input wire logic [KEY_W-1:0] session_key,
  // Result
  output logic [KEY_W-1:0] aes_key
);
  logic [KEY_W-1:0] aes_key_d;
  wire logic sel_root = (key_sel == SEL_ROOT);
  wire logic sel_fixed = (key_sel == SEL_FIXED);
  wire logic sel_session = (key_sel == SEL_SESSION);
  // Locked fixed key gives zeros
  assign aes_key_d = sel_root ? root_key :
                     (sel_fixed && !fixed_locked) ? FIXED_KEY :
                     sel_session ? session_key : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) aes_key <= '0;
    else aes_key <= aes_key_d;
  end

  a_locked_zero_key: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_fixed && fixed_locked |=> aes_key == '0)
    else $error("locked fixed key not zeroed");
  a_root_routed: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_root |=> aes_key == $past(root_key))
    else $error("root key not routed");
endmodule // skl_key_mux

// ### logic/skl_ctrl.sv
// Security subsystem control: enable, lifecycle, root key, key select, AXI4-Lite slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module skl_ctrl
  import skl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Key path to the AES engine
  input wire logic [KEY_W-1:0] session_key,
  output logic [KEY_W-1:0] aes_key,
  // Subsystem status
  output logic subsystem_active,
  output logic idle_block,
  output logic [DMA_LEN_W-1:0] dma_max_len
);
  // ==========================================================
  // State
  logic enable_q;
  logic [LCS_W-1:0] lcs_q;
  logic lcs_valid_q;
  logic fixed_lock_q;
  logic [SEL_W-1:0] sel_q;
  wire logic [3:0] root_written_q;
  wire logic [KEY_W-1:0] root_key_q;
  logic [DMA_LEN_W-1:0] dma_len_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held_q;
  logic w_held_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ==========================================================
  // Write channel capture, either order
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  wire logic have_aw = aw_held_q || aw_take;
  wire logic have_w = w_held_q || w_take;
  wire logic wr_go = have_aw && have_w && !bvalid_q;
  wire logic [ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire logic [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  // Strobes of a held data beat come from the copy taken with it
  wire logic [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  wire logic wr_low = wr_strb[0];
  wire logic [ADDR_W-1:0] wr_word = {wr_addr[ADDR_W-1:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      aw_held_q <= have_aw && !wr_go;
      w_held_q <= have_w && !wr_go;
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (w_take) wdata_q <= s_axi_wdata;
      if (w_take) wstrb_q <= s_axi_wstrb;
    end
  end

  // ==========================================================
  // Write decode
  wire logic hit_en = (wr_word == ADDR_SUBSYSTEM_ENABLE);
  wire logic hit_sel = (wr_word == ADDR_KEY_SOURCE_SELECT);
  wire logic hit_lock = (wr_word == ADDR_FIXED_KEY_LOCK);
  wire logic hit_lcs = (wr_word == ADDR_LIFECYCLE_CONTROL);
  wire logic hit_dma = (wr_word == ADDR_DMA_LENGTH);
  wire logic hit_root = (wr_word >= ADDR_ROOT_KEY_WORD0) && (wr_word <= ADDR_ROOT_KEY_WORD3);
  wire logic [1:0] root_idx = wr_word[3:2];
  wire logic wr_hit = hit_en || hit_sel || hit_lock || hit_lcs || hit_dma || hit_root;
  wire logic wr_do = wr_go && wr_low;
  wire logic [LCS_W-1:0] lcs_in = wr_data[LCS_W-1:0];
  wire logic lcs_ok = (lcs_in == LCS_DEBUG) || (lcs_in == LCS_SECURE);
  wire logic lcs_write = wr_do && hit_lcs && !lcs_valid_q && lcs_ok;
  wire logic debug_mode = lcs_valid_q && (lcs_q == LCS_DEBUG);
  wire logic root_retained = &root_written_q;

  // ==========================================================
  // Control registers, set by any reset to zero except lcs_q (LCS_RESET) and dma_len_q (all ones)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= 1'b0;
      lcs_q <= LCS_RESET;
      lcs_valid_q <= 1'b0;
      fixed_lock_q <= 1'b0;
      sel_q <= SEL_ROOT;
      dma_len_q <= '1;
    end else begin
      if (wr_do && hit_en) enable_q <= wr_data[0];
      if (lcs_write) begin
        lcs_q <= lcs_in;
        lcs_valid_q <= 1'b1;
      end
      if (wr_do && hit_lock && wr_data[0]) fixed_lock_q <= 1'b1;
      if (wr_do && hit_sel) sel_q <= wr_data[SEL_W-1:0];
      if (wr_go && hit_dma && wr_strb[1:0] != 2'b00) dma_len_q <= wr_data[DMA_LEN_W-1:0];
    end
  end

  // ==========================================================
  // Retained root key words, one generate slice per word
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_root
      logic [31:0] word_q;
      logic written_q;
      wire logic word_wr = wr_go && hit_root && (root_idx == 2'(gi));
      wire logic word_ok = debug_mode || !written_q;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          word_q <= '0;
          written_q <= 1'b0;
        end else if (word_wr && word_ok) begin
          word_q <= wr_data;
          written_q <= 1'b1;
        end
      end
      assign root_key_q[32*gi +: 32] = word_q;
      assign root_written_q[gi] = written_q;
    end
  endgenerate

  // ==========================================================
  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ==========================================================
  // Read path; root key words and fixed key never returned
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_q;
  wire logic [ADDR_W-1:0] rd_word = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  wire logic rd_root = (rd_word >= ADDR_ROOT_KEY_WORD0) && (rd_word <= ADDR_ROOT_KEY_WORD3);
  wire logic [31:0] lcs_rd = {23'h0, lcs_valid_q, 4'h0, lcs_q};
  wire logic [31:0] root0_rd = root_retained ? ROOT_RETAINED_VAL : ROOT_EMPTY_VAL;
  wire logic rd_hit = rd_root || rd_word == ADDR_SUBSYSTEM_ENABLE || rd_word == ADDR_KEY_SOURCE_SELECT ||
                      rd_word == ADDR_FIXED_KEY_LOCK || rd_word == ADDR_LIFECYCLE_CONTROL ||
                      rd_word == ADDR_DMA_LENGTH;
  wire logic [31:0] rd_mux =
    (rd_word == ADDR_SUBSYSTEM_ENABLE) ? {31'h0, enable_q} :
    (rd_word == ADDR_KEY_SOURCE_SELECT) ? {30'h0, sel_q} :
    (rd_word == ADDR_FIXED_KEY_LOCK) ? {31'h0, fixed_lock_q} :
    (rd_word == ADDR_ROOT_KEY_WORD0) ? root0_rd :
    (rd_word == ADDR_LIFECYCLE_CONTROL) ? lcs_rd :
    (rd_word == ADDR_DMA_LENGTH) ? {16'h0, dma_len_q} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================================
  // Outputs
  assign subsystem_active = enable_q;
  assign idle_block = enable_q;
  assign dma_max_len = dma_len_q;

  skl_key_mux u_key_mux (
    .aclk(aclk),
    .aresetn(aresetn),
    .key_sel(sel_q),
    .fixed_locked(fixed_lock_q),
    .root_key(root_key_q),
    .session_key(session_key),
    .aes_key(aes_key)
  );

  // ==========================================================
  // Checks
  a_lcs_once: assert property (@(posedge aclk) disable iff (!aresetn)
    lcs_valid_q |=> lcs_valid_q && $stable(lcs_q))
    else $error("lifecycle changed after first write");
  a_lcs_valid_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    lcs_write |=> lcs_valid_q && lcs_q == $past(lcs_in))
    else $error("validity flag did not rise");
  a_secure_root_once: assert property (@(posedge aclk) disable iff (!aresetn)
    lcs_valid_q && lcs_q == LCS_SECURE && root_retained |=> $stable(root_key_q))
    else $error("secure root key overwritten");
  a_debug_root_rewrite: assert property (@(posedge aclk) disable iff (!aresetn)
    debug_mode && wr_go && hit_root && root_idx == 2'd0 |=> root_key_q[31:0] == $past(wr_data))
    else $error("debug root rewrite lost");
  a_lock_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    fixed_lock_q |=> fixed_lock_q)
    else $error("fixed key lock dropped");
  a_root_status: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && rd_word == ADDR_ROOT_KEY_WORD0 |=> s_axi_rdata == {31'h0, $past(root_retained)})
    else $error("root status read wrong");
  a_root_hidden: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && rd_root && rd_word != ADDR_ROOT_KEY_WORD0 |=> s_axi_rdata == 32'h0)
    else $error("root key word leaked");
  a_reset_state: assert property (@(posedge aclk)
    !aresetn |=> lcs_q == LCS_SECURE && !lcs_valid_q && !enable_q && !root_retained)
    else $error("reset state wrong");
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid)
    else $error("write response missing");
  c_lcs_debug: cover property (@(posedge aclk) disable iff (!aresetn) lcs_write && lcs_in == LCS_DEBUG);
  c_root_full: cover property (@(posedge aclk) disable iff (!aresetn) $rose(root_retained));
  c_lock_fixed: cover property (@(posedge aclk) disable iff (!aresetn) fixed_lock_q && sel_q == SEL_FIXED);
endmodule // skl_ctrl

// ### bench/security_key_lifecycle_ctrl_tb.sv
// Self-checking bench for the key and lifecycle control block
`timescale 1ns/1ps
module security_key_lifecycle_ctrl_tb
  import skl_pkg::*;
;
  `define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch at %0t ns: %s", $time, msg); end end
  logic aclk = 1'b0;
  logic aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [KEY_W-1:0] session_key, aes_key, k1, k2;
  logic subsystem_active, idle_block;
  logic [DMA_LEN_W-1:0] dma_max_len;
  logic [33:0] exp_q[$];
  logic [33:0] exp_now;
  logic [1:0] bexp_q[$];
  logic [1:0] bexp_now;
  int n_errors = 0;
  int comparisons = 0;

  always #5 aclk = ~aclk;

  skl_ctrl skl_ctrl_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .session_key(session_key), .aes_key(aes_key),
    .subsystem_active(subsystem_active), .idle_block(idle_block), .dma_max_len(dma_max_len)
  );

  // ==========================================
  // Read data and write response monitor
  always @(negedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      exp_now = exp_q.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, exp_now, "read response")
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      bexp_now = bexp_q.pop_front();
      `CHK(s_axi_bresp, bexp_now, "write response")
    end
  end

  // ==========================================
  // Bus tasks
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic pa, pw, oka, okw, okb;
    bexp_q.push_back(er);
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      oka = pa && s_axi_awready === 1'b1;
      okw = pw && s_axi_wready === 1'b1;
      @(posedge aclk);
      if (oka) begin
        s_axi_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (okw) begin
        s_axi_wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      okb = s_axi_bvalid === 1'b1;
      @(posedge aclk);
    end while (!okb);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [33:0] e);
    logic ok;
    exp_q.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ok = s_axi_arready === 1'b1;
      @(posedge aclk);
    end while (!ok);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ok = s_axi_rvalid === 1'b1;
      @(posedge aclk);
    end while (!ok);
    s_axi_rready <= 1'b0;
  endtask

  // Stimulus stages only register words, no off-chip data to copy
  task automatic load_key(input logic [KEY_W-1:0] k);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_ROOT_KEY_WORD0 + 16'(4 * i), k[32*i +: 32]);
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic tally_and_finish();
    $display("errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================
  // Watchdog
  initial begin
    #100us;
    n_errors++;
    tally_and_finish();
  end

  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(55));
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    session_key = {$urandom, $urandom, $urandom, $urandom};
    k1 = {$urandom, $urandom, $urandom, $urandom};
    k2 = ~k1;
    do_reset();
    rd(ADDR_SUBSYSTEM_ENABLE, {RESP_OKAY, 32'h0000_0000});
    rd(ADDR_LIFECYCLE_CONTROL, {RESP_OKAY, 32'h0000_0002});
    rd(ADDR_ROOT_KEY_WORD0, {RESP_OKAY, ROOT_EMPTY_VAL});
    rd(16'h0ff0, {RESP_SLVERR, 32'h0000_0000});
    `CHK(dma_max_len, 16'hffff, "transfer cap")
    wr(ADDR_DMA_LENGTH, 32'h0001_1234);
    rd(ADDR_DMA_LENGTH, {RESP_OKAY, 32'h0000_1234});
    settle();
    `CHK(dma_max_len, 16'h1234, "transfer cap write")
    wr(16'h0ff0, 32'h0000_0001, RESP_SLVERR);
    s_axi_wstrb <= 4'he;
    wr(ADDR_SUBSYSTEM_ENABLE, 32'h0000_0001);
    s_axi_wstrb <= 4'hf;
    rd(ADDR_SUBSYSTEM_ENABLE, {RESP_OKAY, 32'h0000_0000});
    wr(ADDR_SUBSYSTEM_ENABLE, 32'h0000_0001);
    settle();
    `CHK(subsystem_active, 1'b1, "enable output")
    `CHK(idle_block, 1'b1, "idle hold")
    rd(ADDR_SUBSYSTEM_ENABLE, {RESP_OKAY, 32'h0000_0001});
    wr(ADDR_SUBSYSTEM_ENABLE, 32'h0000_0000);
    settle();
    `CHK(idle_block, 1'b0, "idle release")
    wr(ADDR_LIFECYCLE_CONTROL, 32'h0000_0005);
    rd(ADDR_LIFECYCLE_CONTROL, {RESP_OKAY, 32'h0000_0002});
    wr(ADDR_LIFECYCLE_CONTROL, {28'h0, LCS_SECURE});
    rd(ADDR_LIFECYCLE_CONTROL, {RESP_OKAY, 32'h0000_0102});
    wr(ADDR_LIFECYCLE_CONTROL, {28'h0, LCS_DEBUG});
    rd(ADDR_LIFECYCLE_CONTROL, {RESP_OKAY, 32'h0000_0102});
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_ROOT_KEY_WORD0 + 16'(4 * i), k1[32*i +: 32]);
    end
    rd(ADDR_ROOT_KEY_WORD0, {RESP_OKAY, ROOT_EMPTY_VAL});
    wr(ADDR_ROOT_KEY_WORD3, k1[127:96]);
    rd(ADDR_ROOT_KEY_WORD0, {RESP_OKAY, ROOT_RETAINED_VAL});
    settle();
    `CHK(aes_key, k1, "root key path")
    wr(ADDR_ROOT_KEY_WORD0, k2[31:0]);
    settle();
    `CHK(aes_key, k1, "root word rewrite")
    rd(ADDR_ROOT_KEY_WORD1, {RESP_OKAY, 32'h0000_0000});
    wr(ADDR_KEY_SOURCE_SELECT, {30'h0, SEL_SESSION});
    settle();
    `CHK(aes_key, session_key, "session key path")
    wr(ADDR_KEY_SOURCE_SELECT, {30'h0, SEL_FIXED});
    settle();
    `CHK(aes_key != '0, 1'b1, "fixed key path")
    wr(ADDR_FIXED_KEY_LOCK, 32'h0000_0001);
    settle();
    `CHK(aes_key, 128'h0, "locked fixed key")
    rd(ADDR_FIXED_KEY_LOCK, {RESP_OKAY, 32'h0000_0001});
    do_reset();
    rd(ADDR_LIFECYCLE_CONTROL, {RESP_OKAY, 32'h0000_0002});
    rd(ADDR_ROOT_KEY_WORD0, {RESP_OKAY, ROOT_EMPTY_VAL});
    rd(ADDR_FIXED_KEY_LOCK, {RESP_OKAY, 32'h0000_0000});
    wr(ADDR_LIFECYCLE_CONTROL, {28'h0, LCS_DEBUG});
    load_key(k1);
    load_key(k2);
    settle();
    `CHK(aes_key, k2, "debug root rewrite")
    repeat (5) @(posedge aclk);
    tally_and_finish();
  end
endmodule // security_key_lifecycle_ctrl_tb
